/* File: host_port_pkg.sv */
// Shared constants and types of the multiplexed host bus port.
// Assumes a single core clock at 40 MHz; every time below is turned into core cycles here.
package host_port_pkg;

  // Core clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 25;

  // Recovery between two accesses to this device: whole core cycles plus a fixed time.
  localparam int RECOV_CLK_CYC = 6;
  localparam int RECOV_NS      = 200;
  // The fixed part is a least time, so it rounds up.
  localparam int RECOV_CYC     = RECOV_CLK_CYC + (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Least time for both strobes low together to count as a reset.
  localparam int RESET_LOW_NS  = 30;
  localparam int RESET_CYC_RAW = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC     = (RESET_CYC_RAW < 1) ? 1 : RESET_CYC_RAW;

  // Address decode fields of the latched address byte.
  localparam int ADR_CHAN_RIGHT = 0;
  localparam int ADR_CHAN_LEFT  = 5;
  localparam int ADR_REG_LSB    = 1;
  localparam int ADR_REG_W      = 4;

  // Register numbers inside a channel.
  localparam logic [3:0] REG_RX_ERR   = 4'h1;
  localparam logic [3:0] REG_VECTOR   = 4'h2;
  localparam logic [3:0] REG_PENDING  = 4'h3;
  localparam logic [3:0] REG_BUFFER   = 4'h8;
  localparam logic [3:0] REG_MASTER   = 4'h9;
  localparam logic [3:0] REG_TC_LOW   = 4'hC;
  localparam logic [3:0] REG_TC_HIGH  = 4'hD;

  // Master interrupt control fields.
  localparam int MIC_STATUS_BIT = 0;
  localparam int MIC_NO_VEC_BIT = 1;

  // Field of the vector replaced by interrupt status.
  localparam int VEC_STAT_LSB   = 1;
  localparam int VEC_STAT_W     = 3;

  // Reset values of the shared registers.
  localparam logic [7:0] VECTOR_RESET = 8'h00;
  localparam logic [7:0] MASTER_RESET = 8'h00;

  // Number of interrupt sources: receive, transmit, status for channel A then channel B.
  localparam int NUM_SRC = 6;
  // Status code shown when nothing is pending.
  localparam logic [2:0] STAT_NONE = 3'h7;

  // Phase of a bus transaction as seen through the synchronisers.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } cycle_state_t;

endpackage

/* File: bus_sync_if.sv */
// Synchronised view of the host bus pins, passed from the synchroniser to the port logic.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface bus_sync_if;
  logic       as_low;     // Address strobe is low, after synchronisation.
  logic       ds_low;     // Data strobe is low, after synchronisation.
  logic       as_rise;    // One-cycle pulse on the address strobe rising.
  logic       ds_fall;    // One-cycle pulse on the data strobe falling.
  logic       ds_rise;    // One-cycle pulse on the data strobe rising.
  logic [7:0] ad_now;     // Bus lines aligned with the strobe levels.
  logic [7:0] ad_prev;    // Bus lines one cycle earlier, still inside the strobe pulse.
  logic       cs0_n_prev; // Low-active select, aligned with ad_prev.
  logic       ack_n_prev; // Acknowledge input, aligned with ad_prev.
  logic       rw_now;     // Read-not-write, aligned with ad_now.
  logic       cs1_now;    // High-active select, aligned with ad_now.
  logic       iei_now;    // Chain enable input, aligned with ad_now.

  modport src (output as_low, ds_low, as_rise, ds_fall, ds_rise, ad_now, ad_prev,
               output cs0_n_prev, ack_n_prev, rw_now, cs1_now, iei_now);
  modport dst (input  as_low, ds_low, as_rise, ds_fall, ds_rise, ad_now, ad_prev,
               input  cs0_n_prev, ack_n_prev, rw_now, cs1_now, iei_now);
endinterface

/* File: strobe_sync.sv */
// Two-stage synchroniser for every host bus input, plus strobe edge detection.
// Assumes the pins are asynchronous to clk_i; all of them pass the same two flops so
// that the address stays aligned with its strobe edge.
`timescale 1ns/100ps
module strobe_sync (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       addr_strobe_n_i,
  input  wire logic       data_strobe_n_i,
  input  wire logic       chip_sel_low_n_i,
  input  wire logic       chip_sel_high_i,
  input  wire logic       read_not_write_i,
  input  wire logic       irq_ack_n_i,
  input  wire logic       chain_enable_in_i,
  input  wire logic [7:0] bus_i,
  bus_sync_if.src         s
);

  // Pin order in the raw vector: bus, strobes, selects, direction, acknowledge, chain.
  logic [14:0] meta_q;  // First stage; read only by the second stage.
  logic [14:0] sync_q;  // Second stage; safe to use.
  logic [14:0] last_q;  // Third stage for edges and for the address as it stood.
  logic [14:0] raw;     // Gathered pin levels.

  assign raw = {chain_enable_in_i, irq_ack_n_i, read_not_write_i, chip_sel_high_i,
                chip_sel_low_n_i, data_strobe_n_i, addr_strobe_n_i, bus_i};

  // Strobes idle high, so the flops reset to one and no false edge appears.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= 15'h7F00;
      sync_q <= 15'h7F00;
      last_q <= 15'h7F00;
    end else begin
      meta_q <= raw;     // RULE3
      sync_q <= meta_q;  // RULE3
      last_q <= sync_q;
    end
  end

  // Edges are taken from the settled stages only, never from the first flop.
  assign s.as_low     = ~sync_q[8];
  assign s.ds_low     = ~sync_q[9];
  assign s.as_rise    = sync_q[8] & ~last_q[8];  // RULE3
  assign s.ds_fall    = ~sync_q[9] & last_q[9];  // RULE3
  assign s.ds_rise    = sync_q[9] & ~last_q[9];
  assign s.ad_now     = sync_q[7:0];
  assign s.ad_prev    = last_q[7:0];
  assign s.cs0_n_prev = last_q[10];
  assign s.ack_n_prev = last_q[13];
  assign s.rw_now     = sync_q[12];
  assign s.cs1_now    = sync_q[11];
  assign s.iei_now    = sync_q[14];

endmodule

/* File: muxed_bus_host_interface.sv */
// Host side of a two-channel serial controller: multiplexed read, write and acknowledge
// cycles, shared vector and master control registers, daisy chain and strobe reset.
// Assumes per-channel registers live in the channel logic, which takes write pulses and
// offers its read values on plain ports in the core clock domain.
`timescale 1ns/100ps

// Operation
// [RULE1] Host waits recovery between own accesses.
// [RULE2] Recovery counts only own transactions.
// [RULE3] Strobes pass two-flop synchronisers first.
// [RULE4] Address rise latches address, select, acknowledge.
// [RULE5] Host reads with direction high, select high.
// [RULE6] Read data driven only while strobe low.
// [RULE7] Host writes with direction low, select high.
// [RULE8] Write captures bus byte at strobe low.
// [RULE9] Acknowledge ignores address, selects and direction.
// [RULE10] Host lets chain settle before vector.
// [RULE11] Own acknowledge needs pending and chain in.
// [RULE12] Owned acknowledge drives vector when enabled.
// [RULE13] Owned acknowledge sets source in-service latch.
// [RULE14] Both strobes low long enough resets.
// [RULE15] Vector readback plain on A, status on B.
// [RULE16] Pending bits readable on channel A only.
// [RULE17] Vector and master control shared by channels.
// [RULE18] Receive errors grouped in one register.
// [RULE19] Time constant bytes readable per channel.
// [RULE20] Buffer read gives data, write sends.
// [RULE21] Software programs format, interrupts, then enables.
// [RULE22] Channel bit from bit 0 or 5.
// [RULE23] Register number from address bits 4:1.
// [RULE24] Any in-service latch drives chain out low.
// [RULE25] Foreign acknowledge keeps drivers off, latches unchanged.
module muxed_bus_host_interface #(
  parameter int RECOVERY_CYCLES = host_port_pkg::RECOV_CYC,
  parameter int RESET_CYCLES    = host_port_pkg::RESET_CYC
) (
  input  wire logic                             clk_i,
  input  wire logic                             reset_i,
  input  wire logic                             addr_strobe_n_i,
  input  wire logic                             data_strobe_n_i,
  input  wire logic                             chip_sel_low_n_i,
  input  wire logic                             chip_sel_high_i,
  input  wire logic                             read_not_write_i,
  input  wire logic                             irq_ack_n_i,
  input  wire logic                             chain_enable_in_i,
  input  wire logic [7:0]                       bus_i,
  output logic      [7:0]                       bus_o,
  output logic                                  bus_oe_o,
  output logic                                  chain_enable_out_o,
  output logic                                  device_reset_o,
  output logic                                  recovery_violation_o,
  input  wire logic                             shift_left_i,
  input  wire logic [host_port_pkg::NUM_SRC-1:0] irq_pending_bits_i,
  input  wire logic                             ius_clear_i,
  input  wire logic [15:0]                      rx_error_status_i,
  input  wire logic [15:0]                      rx_data_i,
  input  wire logic [15:0]                      time_const_low_i,
  input  wire logic [15:0]                      time_const_high_i,
  output logic                                  wr_valid_o,
  output logic                                  wr_chan_a_o,
  output logic      [3:0]                       wr_reg_o,
  output logic      [7:0]                       wr_data_o,
  output logic      [1:0]                       rx_pop_o,
  output logic      [host_port_pkg::NUM_SRC-1:0] in_service_latch_o,
  output logic      [7:0]                       vector_reg_o,
  output logic      [7:0]                       master_irq_ctrl_reg_o
);

  localparam int NS = host_port_pkg::NUM_SRC;

  // The counters below are eight and four bits wide; refuse settings they cannot hold.
  if (RECOVERY_CYCLES < 1 || RECOVERY_CYCLES > 255) begin : bad_recovery
    $error("RECOVERY_CYCLES must be within 1 to 255");
  end
  if (RESET_CYCLES < 1 || RESET_CYCLES > 15) begin : bad_reset
    $error("RESET_CYCLES must be within 1 to 15");
  end

  // Lowest set bit as one-hot; lowest index is highest priority.
  function automatic logic [NS-1:0] first_set(input logic [NS-1:0] v);
    logic [NS-1:0] r;
    r = v & (~v + 1'b1);
    return r;
  endfunction

  // Index of a one-hot source as a status code.
  function automatic logic [2:0] src_code(input logic [NS-1:0] oh);
    logic [2:0] c;
    c = host_port_pkg::STAT_NONE;
    for (int i = NS - 1; i >= 0; i--) begin
      if (oh[i]) begin
        c = 3'(i);
      end
    end
    return c;
  endfunction

  bus_sync_if s ();

  // All pins go through the synchroniser before any decision is made on them.
  strobe_sync u_sync (
    .clk_i             (clk_i),
    .reset_i           (reset_i),
    .addr_strobe_n_i   (addr_strobe_n_i),
    .data_strobe_n_i   (data_strobe_n_i),
    .chip_sel_low_n_i  (chip_sel_low_n_i),
    .chip_sel_high_i   (chip_sel_high_i),
    .read_not_write_i  (read_not_write_i),
    .irq_ack_n_i       (irq_ack_n_i),
    .chain_enable_in_i (chain_enable_in_i),
    .bus_i             (bus_i),
    .s                 (s)
  );

  host_port_pkg::cycle_state_t st_q, st_d;  // Transaction phase.
  logic          ack_q;      // Current cycle is an acknowledge.
  logic          sel_q;      // Low-active select was latched active in a cycle that is not an acknowledge.
  logic          chan_a_q;   // Latched channel is A.
  logic [3:0]    reg_q;      // Latched register number.
  logic          drive_q;    // Read data or vector is due on the bus.
  logic          own_q;      // Current transaction involves this device.
  logic [7:0]    rec_q;      // Recovery cycles still to run.
  logic [3:0]    low_cnt_q;  // Consecutive cycles with both strobes low.
  logic [7:0]    vector_q;   // Shared interrupt vector.
  logic [7:0]    mic_q;      // Shared master interrupt control.
  logic [NS-1:0] ius_q;      // In-service latches.

  // Decode of the latched address and of the strobe events.
  wire       chan_a_w  = shift_left_i ? s.ad_prev[host_port_pkg::ADR_CHAN_LEFT]   // RULE22
                                      : s.ad_prev[host_port_pkg::ADR_CHAN_RIGHT]; // RULE22
  wire [3:0] reg_w     = s.ad_prev[host_port_pkg::ADR_REG_LSB +: host_port_pkg::ADR_REG_W]; // RULE23
  wire       in_addr   = (st_q == host_port_pkg::ST_ADDR);
  wire       acc_fire  = s.ds_fall & in_addr & sel_q & ~ack_q & s.cs1_now;  // RULE9
  wire       wr_fire   = acc_fire & ~s.rw_now;
  wire       rd_fire   = acc_fire & s.rw_now;
  wire       ack_fall  = s.ds_fall & in_addr & ack_q;
  wire       own_ack   = ack_fall & s.iei_now & (|irq_pending_bits_i);  // RULE11
  wire       vec_fire  = own_ack & ~mic_q[host_port_pkg::MIC_NO_VEC_BIT];  // RULE12
  wire       involved  = acc_fire | own_ack;
  wire       both_low  = s.as_low & s.ds_low;
  wire       rst_d     = both_low && (low_cnt_q >= 4'(RESET_CYCLES - 1));  // RULE14

  // Interrupt status and the two forms of the vector.
  wire [NS-1:0] top_pend = first_set(irq_pending_bits_i);
  wire [2:0]    stat_w   = src_code(top_pend);
  wire [7:0]    vec_mod  = {vector_q[7:4], stat_w, vector_q[0]};
  wire [7:0]    ack_vec  = mic_q[host_port_pkg::MIC_STATUS_BIT] ? vec_mod : vector_q;

  // Per-channel inputs are {B, A}.
  wire [7:0] err_sel = chan_a_q ? rx_error_status_i[7:0] : rx_error_status_i[15:8];
  wire [7:0] dat_sel = chan_a_q ? rx_data_i[7:0]         : rx_data_i[15:8];
  wire [7:0] tcl_sel = chan_a_q ? time_const_low_i[7:0]  : time_const_low_i[15:8];
  wire [7:0] tch_sel = chan_a_q ? time_const_high_i[7:0] : time_const_high_i[15:8];
  wire [7:0] pend_w  = {{(8 - NS){1'b0}}, irq_pending_bits_i};
  wire [7:0] rd_data =
      (reg_q == host_port_pkg::REG_RX_ERR)  ? err_sel :                      // RULE18
      (reg_q == host_port_pkg::REG_VECTOR)  ? (chan_a_q ? vector_q : vec_mod) : // RULE15
      (reg_q == host_port_pkg::REG_PENDING) ? (chan_a_q ? pend_w : 8'h00) :  // RULE16
      (reg_q == host_port_pkg::REG_BUFFER)  ? dat_sel :                      // RULE20
      (reg_q == host_port_pkg::REG_TC_LOW)  ? tcl_sel :                      // RULE19
      (reg_q == host_port_pkg::REG_TC_HIGH) ? tch_sel : 8'h00;               // RULE19

  // Writes to the shared registers stay here; the rest go out to the channels.
  wire wr_vec  = wr_fire && (reg_q == host_port_pkg::REG_VECTOR);  // RULE17
  wire wr_mic  = wr_fire && (reg_q == host_port_pkg::REG_MASTER);  // RULE17
  wire wr_out  = wr_fire & ~wr_vec & ~wr_mic;
  wire rd_pop  = rd_fire && (reg_q == host_port_pkg::REG_BUFFER);

  // In-service set by owned acknowledge, cleared highest first by the channel logic.
  wire [NS-1:0] ius_set = own_ack ? first_set(irq_pending_bits_i) : '0;  // RULE13
  wire [NS-1:0] ius_clr = ius_clear_i ? first_set(ius_q) : '0;
  wire          ack_act = ack_q & (st_q != host_port_pkg::ST_IDLE);
  wire          ceo_d   = s.iei_now & ~(|ius_q) & ~(ack_act & (|irq_pending_bits_i)); // RULE24

  // Phase sequence: address rise opens a cycle, data strobe falls then rises.
  always_comb begin
    st_d = st_q;
    case (st_q)
      host_port_pkg::ST_IDLE: st_d = s.as_rise ? host_port_pkg::ST_ADDR : st_q;
      host_port_pkg::ST_ADDR: st_d = s.ds_fall ? host_port_pkg::ST_DATA : st_q;
      host_port_pkg::ST_DATA: st_d = s.ds_rise ? host_port_pkg::ST_IDLE : st_q;
      default:                st_d = host_port_pkg::ST_IDLE;
    endcase
    // A new address strobe always starts over, even if a strobe was missed.
    if (s.as_rise) begin
      st_d = host_port_pkg::ST_ADDR;
    end
  end

  // Address phase latches; the strobe reset drops any cycle in flight.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q     <= host_port_pkg::ST_IDLE;
      ack_q    <= 1'b0;
      sel_q    <= 1'b0;
      chan_a_q <= 1'b0;
      reg_q    <= 4'h0;
    end else if (device_reset_o) begin
      st_q     <= host_port_pkg::ST_IDLE;
      sel_q    <= 1'b0;
      ack_q    <= 1'b0;
    end else begin
      st_q <= st_d;
      if (s.as_rise) begin
        ack_q    <= ~s.ack_n_prev;                    // RULE4
        sel_q    <= s.ack_n_prev & ~s.cs0_n_prev;     // RULE9
        chan_a_q <= chan_a_w;                         // RULE4
        reg_q    <= reg_w;                            // RULE4
      end
    end
  end

  // Bus drivers: loaded at the strobe fall, enabled only while the strobe stays low.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      drive_q  <= 1'b0;
      bus_o    <= 8'h00;
      bus_oe_o <= 1'b0;
    end else begin
      if (rd_fire) begin
        bus_o <= rd_data;
      end else if (vec_fire) begin
        bus_o <= ack_vec;                             // RULE12
      end
      drive_q <= rd_fire | vec_fire | (drive_q & ~(s.ds_rise | s.as_rise));
      bus_oe_o <= s.ds_low & (drive_q | rd_fire | vec_fire);  // RULE6 RULE25
    end
  end

  // Shared registers, write pulses and receive pops.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      vector_q    <= host_port_pkg::VECTOR_RESET;
      mic_q       <= host_port_pkg::MASTER_RESET;
      wr_valid_o  <= 1'b0;
      wr_chan_a_o <= 1'b0;
      wr_reg_o    <= 4'h0;
      wr_data_o   <= 8'h00;
      rx_pop_o    <= 2'b00;
    end else begin
      if (device_reset_o) begin
        vector_q <= host_port_pkg::VECTOR_RESET;
        mic_q    <= host_port_pkg::MASTER_RESET;
      end else if (wr_vec) begin
        vector_q <= s.ad_now;                         // RULE8
      end else if (wr_mic) begin
        mic_q <= s.ad_now;                            // RULE8
      end
      wr_valid_o <= wr_out;                           // RULE20
      if (wr_out) begin
        wr_chan_a_o <= chan_a_q;
        wr_reg_o    <= reg_q;
        wr_data_o   <= s.ad_now;                      // RULE8
      end
      rx_pop_o <= {rd_pop & ~chan_a_q, rd_pop & chan_a_q};  // RULE20
    end
  end

  // One latch per source; the set wins over a clear landing in the same cycle.
  for (genvar i = 0; i < NS; i++) begin : g_ius
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        ius_q[i] <= 1'b0;
      end else if (device_reset_o | ius_set[i] | ius_clr[i]) begin
        ius_q[i] <= ~device_reset_o & ius_set[i];     // RULE13
      end
    end
  end

  // Chain output, recovery watch and strobe reset detection.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      chain_enable_out_o   <= 1'b0;
      own_q                <= 1'b0;
      rec_q                <= 8'h00;
      recovery_violation_o <= 1'b0;
      low_cnt_q            <= 4'h0;
      device_reset_o       <= 1'b0;
    end else begin
      chain_enable_out_o <= ceo_d;                    // RULE24
      own_q <= involved | (own_q & ~s.ds_rise);
      // Only the end of a transaction that involved us starts the count.
      if (s.ds_rise & own_q) begin
        rec_q <= 8'(RECOVERY_CYCLES);                 // RULE2
      end else if (rec_q != 8'h00) begin
        rec_q <= rec_q - 8'h01;
      end
      recovery_violation_o <= involved & (rec_q != 8'h00);  // RULE1
      low_cnt_q <= both_low ? (low_cnt_q + {3'h0, low_cnt_q != 4'hF}) : 4'h0;
      device_reset_o <= rst_d;                        // RULE14
    end
  end

  assign in_service_latch_o    = ius_q;
  assign vector_reg_o          = vector_q;
  assign master_irq_ctrl_reg_o = mic_q;

  bus_drive_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
    bus_oe_o |-> $past(s.ds_low))
    else $error("bus driven while data strobe high");
  chain_block_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE24
    (|ius_q) |=> !chain_enable_out_o)
    else $error("chain out high while a source is in service");
  ius_set_a: assert property (@(posedge clk_i) disable iff (reset_i || device_reset_o) // RULE13
    own_ack |=> ((ius_q & $past(first_set(irq_pending_bits_i))) != '0))
    else $error("owned acknowledge did not set in-service latch");
  foreign_ack_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE25
    (ack_fall && !own_ack && !ius_clear_i && !device_reset_o) |=> (ius_q == $past(ius_q))
    ##0 !bus_oe_o)
    else $error("foreign acknowledge changed latches or drove bus");
  strobe_reset_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE14
    (both_low [*2]) |=> device_reset_o)
    else $error("coincident strobes did not reset");
  no_reset_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE14
    !both_low |=> !device_reset_o)
    else $error("reset without coincident strobes");
  ack_write_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
    (ack_q && s.ds_fall) |=> !wr_valid_o && $stable(vector_q) && $stable(mic_q))
    else $error("acknowledge cycle performed a write");
  wr_capture_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
    wr_out |=> wr_valid_o && (wr_data_o == $past(s.ad_now)))
    else $error("write byte not captured");
  vec_read_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE15
    (rd_fire && reg_q == host_port_pkg::REG_VECTOR) |=>
      (bus_o == ($past(chan_a_q) ? $past(vector_q) : $past(vec_mod))))
    else $error("vector readback wrong for channel");
  vec_drive_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE12
    vec_fire |=> (bus_o == $past(ack_vec)) && (bus_oe_o == $past(s.ds_low)))
    else $error("owned acknowledge did not present vector");

endmodule

/* File: host_cpu_model.sv */
// Host CPU model: drives the strobes, selects and multiplexed lines of the port.
// Assumes the bench calls its tasks; strobes, selects and driven bytes change only at falling clock edges.
`timescale 1ns/100ps
module host_cpu_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dout_i,
  input  wire logic       doe_i,
  output logic            as_n_o = 1'b1,
  output logic            ds_n_o = 1'b1,
  output logic            cs0_n_o = 1'b1,
  output logic            cs1_o = 1'b0,
  output logic            rw_o = 1'b1,
  output logic            ack_n_o = 1'b1,
  output logic      [7:0] bus_o
);
  logic [7:0] hv = 8'h00;  // Byte the host puts on the lines.
  logic       hd = 1'b0;   // High while the host drives the lines.
  logic [7:0] pat = 8'h00; // Released lines change every cycle so stale data never passes.
  int         gap = 16;    // Idle cycles after each access; the bench may shorten it.
  // Filler pattern for undriven lines.
  always @(posedge clk_i) pat <= pat + 8'h35;
  assign bus_o = doe_i ? dout_i : (hd ? hv : pat);
  // One whole bus cycle; ak low makes it an acknowledge, q is what the lines showed.
  task automatic cyc(input logic [7:0] a, input logic ak, input logic rd, input logic c1,
                     input logic [7:0] wd, output logic [7:0] q);
    @(negedge clk_i);
    hv = a;
    hd = 1'b1;
    cs0_n_o = 1'b0;
    ack_n_o = ak;
    as_n_o = 1'b0;
    repeat (3) @(negedge clk_i);
    as_n_o = 1'b1;
    repeat (2) @(negedge clk_i);
    hd = !rd && ak;
    hv = wd;
    rw_o = rd;
    cs1_o = c1;
    ds_n_o = 1'b0;
    repeat (8) @(negedge clk_i);
    q = bus_o;
    ds_n_o = 1'b1;
    repeat (2) @(negedge clk_i);
    hd = 1'b0;
    cs0_n_o = 1'b1;
    ack_n_o = 1'b1;
    repeat (gap) @(negedge clk_i);
  endtask
  // Both strobes low together, long enough to reset the port.
  task automatic strobe_reset();
    @(negedge clk_i);
    as_n_o = 1'b0;
    ds_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    as_n_o = 1'b1;
    ds_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

/* File: muxed_bus_host_interface_tb.sv */
// Self-checking bench of the host port: register access, acknowledge and strobe reset.
// Assumes the host model above; expected values come from the channel inputs set here.
`timescale 1ns/100ps
module muxed_bus_host_interface_tb;
  logic       clk_i = 1'b0, reset_i = 1'b1, chain_enable_in = 1'b1, sl = 1'b0, iclr = 1'b0;
  logic       as_n, ds_n, cs0_n, cs1, rw, ack_n, doe, chain_enable_out, wv, wa, rv, dr;
  logic       rvs = 1'b0, drs = 1'b0; // Sticky copies of the violation and reset pulses.
  logic [1:0] rxp, pops = 2'b00;      // Receive pops, and their sticky copy.
  logic [7:0] bus, dout, wd, vec, mic, q;
  logic [3:0] wr;
  logic [5:0] pend = 6'h00, in_service_latch;
  int         error_cnt = 0, n_tests = 0;
  // Channel read values: receive errors, time constant low and high, receive data.
  logic [15:0] rxe = 16'h3C96, tcl = 16'h7E12, tch = 16'h4BD1, rxd = 16'hC35A;
  logic [7:0] ra [4] = '{8'h03, 8'h19, 8'h1A, 8'h0B};
  logic [7:0] rx [4] = '{8'h96, 8'h12, 8'h4B, 8'h00};
  initial forever #12.5 clk_i = ~clk_i;
  host_cpu_model cpu (.clk_i(clk_i), .dout_i(dout), .doe_i(doe), .as_n_o(as_n), .ds_n_o(ds_n),
    .cs0_n_o(cs0_n), .cs1_o(cs1), .rw_o(rw), .ack_n_o(ack_n), .bus_o(bus));
  muxed_bus_host_interface uut (.clk_i(clk_i), .reset_i(reset_i), .addr_strobe_n_i(as_n),
    .data_strobe_n_i(ds_n), .chip_sel_low_n_i(cs0_n), .chip_sel_high_i(cs1),
    .read_not_write_i(rw), .irq_ack_n_i(ack_n), .chain_enable_in_i(chain_enable_in), .bus_i(bus),
    .bus_o(dout), .bus_oe_o(doe), .chain_enable_out_o(chain_enable_out), .device_reset_o(dr),
    .recovery_violation_o(rv), .shift_left_i(sl), .irq_pending_bits_i(pend),
    .ius_clear_i(iclr), .rx_error_status_i(rxe), .rx_data_i(rxd),
    .time_const_low_i(tcl), .time_const_high_i(tch), .wr_valid_o(wv), .wr_chan_a_o(wa),
    .wr_reg_o(wr), .wr_data_o(wd), .rx_pop_o(rxp), .in_service_latch_o(in_service_latch),
    .vector_reg_o(vec), .master_irq_ctrl_reg_o(mic));
  // One-cycle pulses are gathered here so that a later check cannot miss them.
  always @(posedge clk_i) begin
    if (!reset_i) begin
      rvs  <= rvs | rv;
      drs  <= drs | dr;
      pops <= pops | rxp;
    end
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog: the sequence needs about 440 cycles.
  initial begin
    #(25 * 5000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    cpu.cyc(8'hC5, 1'b1, 1'b0, 1'b1, 8'hA0, q); // Vector through channel A, top bits set.
    chk("vector", vec, 8'hA0);
    cpu.cyc(8'h12, 1'b1, 1'b0, 1'b1, 8'h01, q); // Master control through channel B.
    chk("master", mic, 8'h01);
    cpu.cyc(8'h05, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk("vec read A", q, 8'hA0);
    cpu.cyc(8'h04, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk("vec read B", q, 8'hAE);
    for (int i = 0; i < 4; i++) begin
      cpu.cyc(ra[i], 1'b1, 1'b1, 1'b1, 8'h00, q);
      chk("reg read", q, rx[i]);
    end
    chk("quiet flags", {6'h00, rvs, drs}, 8'h00);
    cpu.gap = 0; // The access after this one breaks the recovery time on purpose.
    cpu.cyc(8'h10, 1'b1, 1'b1, 1'b1, 8'h00, q); // Receive buffer of channel B.
    chk("rx data B", q, 8'hC3);
    chk("pop B", {6'h00, pops}, 8'h02);
    cpu.gap = 16;
    sl = 1'b1; // Channel bit now comes from bit 5.
    cpu.cyc(8'h30, 1'b1, 1'b0, 1'b1, 8'h5B, q);
    chk("wr chan", {7'h00, wa}, 8'h01);
    chk("wr reg", {4'h0, wr}, 8'h08);
    chk("wr data", wd, 8'h5B);
    chk("recovery", {7'h00, rvs}, 8'h01);
    sl = 1'b0;
    cpu.cyc(8'h05, 1'b1, 1'b0, 1'b0, 8'hFF, q); // High select low: refused.
    chk("unselected", vec, 8'hA0);
    pend = 6'h08;
    cpu.cyc(8'hFF, 1'b0, 1'b0, 1'b0, 8'h00, q); // Selects ignored in acknowledge.
    chk("ack vector", q, 8'hA6);
    chk("in service", {2'h0, in_service_latch}, 8'h08);
    chk("chain out", {7'h00, chain_enable_out}, 8'h00);
    pend = 6'h00;
    iclr = 1'b1;
    @(negedge clk_i);
    iclr = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("chain free", {7'h00, chain_enable_out}, 8'h01);
    pend = 6'h01;
    chain_enable_in = 1'b0; // A higher device owns this acknowledge.
    cpu.cyc(8'h00, 1'b0, 1'b1, 1'b1, 8'h00, q);
    chk("foreign ack", {2'h0, in_service_latch}, 8'h00);
    chain_enable_in = 1'b1;
    pend = 6'h00;
    cpu.strobe_reset();
    chk("reset vec", vec, 8'h00);
    chk("reset mic", mic, 8'h00);
    chk("reset seen", {7'h00, drs}, 8'h01);
    tally_and_finish();
  end
endmodule
